// *** include/ldr_pkg.sv ***
// Package: display memory address map constants and carrier types
package ldr_pkg;
   // ----------------------------------------
   // Matrix and memory modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      LDR_TYPE_9X10 = 2'h0,
      LDR_TYPE_12X12 = 2'h1,
      LDR_TYPE_16X16 = 2'h2
   } ldr_matrix_e;

   // Host command codes
   localparam logic [7:0] LDR_CMD_WR_FADE = 8'h82;

   // Last address of each layout before the pointer wraps
   localparam logic [7:0] LDR_BIN_LAST_9X10 = 8'h1D;
   localparam logic [7:0] LDR_BIN_LAST_12X12 = 8'h11;
   localparam logic [7:0] LDR_BIN_LAST_16X16 = 8'h1F;
   localparam logic [7:0] LDR_GRAY_LAST_9X10 = 8'hB3;
   localparam logic [7:0] LDR_GRAY_LAST_12X12 = 8'hBB;
   localparam logic [7:0] LDR_GRAY_LAST_16X16 = 8'hFF;
   localparam logic [7:0] LDR_FADE_LAST = 8'h7F;

   // Memory sizes
   localparam int LDR_BIN_DEPTH = 32;
   localparam int LDR_GRAY_DEPTH = 256;
   localparam int LDR_FADE_DEPTH = 128;
   localparam int LDR_DOTS_9X10 = 18;
   localparam logic [7:0] LDR_ZERO_ADDR = 8'h00;

   // Host write stream
   typedef struct packed {
      logic set_ptr;
      logic wr_fade_cmd;
      logic wr_data;
      logic [7:0] data;
   } ldr_host_s;

   // Dot lookup from the scanner
   typedef struct packed {
      logic [3:0] common;
      logic [4:0] dot;
   } ldr_dot_s;
endpackage

// *** hdl/ldr_ram_map.sv ***
// Display memory, fade memory and address pointer of the matrix driver
//
// Function
// - Binary mode: one bit per LED, one lights the dot, zero darkens it.
// - Host sets pointer first; each data byte lands at pointer, single or burst.
// - 9x10 binary: three bytes per common, wrap after 1Dh.
// - 12x12 binary: two commons share three bytes, wrap after 11h.
// - 16x16 binary: two bytes per common, wrap after 1Fh.
// - Gray mode: one intensity byte per dot, 256 bytes.
// - 9x10 gray: 18 consecutive bytes per common, wrap after B3h.
// - 12x12 gray: address 16(n-1)+(k-1), wrap after BBh.
// - 16x16 gray: address 16(n-1)+(k-1), wrap after FFh.
// - Separate 128-byte fade memory written after the 82h command.
`timescale 1ns/100ps
module ldr_ram_map (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Configuration
   input wire ldr_pkg::ldr_matrix_e matrix_type,
   input wire logic gray_mode,
   // Host write stream
   input wire ldr_pkg::ldr_host_s host,
   // Scanner lookup
   input wire ldr_pkg::ldr_dot_s scan,
   // Outputs
   output logic [7:0] ptr,
   output logic fade_sel,
   output logic [7:0] dot_level,
   output logic [7:0] dot_fade
);
   // ----------------------------------------
   // Storage; the memories are not cleared by reset
   // ----------------------------------------
   logic [7:0] bin_mem [ldr_pkg::LDR_BIN_DEPTH];
   logic [7:0] gray_mem [ldr_pkg::LDR_GRAY_DEPTH];
   logic [7:0] fade_mem [ldr_pkg::LDR_FADE_DEPTH];
   logic [7:0] ptr_r, ptr_nxt;
   logic fade_r, fade_nxt;
   logic [7:0] level_r, level_nxt;
   logic [7:0] fade_out_r, fade_out_nxt;

   // Last address for the active layout
   function automatic logic [7:0] last_addr(input ldr_pkg::ldr_matrix_e t, input logic g,
                                            input logic f);
      logic [7:0] a;
      a = ldr_pkg::LDR_BIN_LAST_16X16;
      if (f) begin
         a = ldr_pkg::LDR_FADE_LAST;
      end else begin
         case (t)
            ldr_pkg::LDR_TYPE_9X10: begin
               a = g ? ldr_pkg::LDR_GRAY_LAST_9X10 : ldr_pkg::LDR_BIN_LAST_9X10;
            end
            ldr_pkg::LDR_TYPE_12X12: begin
               a = g ? ldr_pkg::LDR_GRAY_LAST_12X12 : ldr_pkg::LDR_BIN_LAST_12X12;
            end
            default: begin
               a = g ? ldr_pkg::LDR_GRAY_LAST_16X16 : ldr_pkg::LDR_BIN_LAST_16X16;
            end
         endcase
      end
      return a;
   endfunction

   // ----------------------------------------
   // Pointer and target select
   // ----------------------------------------
   // Pointer steps on each data byte and wraps at the layout end
   always_comb begin
      ptr_nxt = ptr_r;
      fade_nxt = fade_r;
      if (host.set_ptr) begin
         ptr_nxt = host.data;
         fade_nxt = 1'b0;
      end else if (host.wr_fade_cmd) begin
         fade_nxt = 1'b1;
      end else if (host.wr_data) begin
         if (ptr_r >= last_addr(matrix_type, gray_mode, fade_r)) begin
            ptr_nxt = ldr_pkg::LDR_ZERO_ADDR;
         end else begin
            ptr_nxt = ptr_r + 8'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ptr_r <= 8'h00;
         fade_r <= 1'b0;
      end else begin
         ptr_r <= ptr_nxt;
         fade_r <= fade_nxt;
      end
   end

   // Memory writes land at the current pointer; no reset by design
   always_ff @(posedge clk) begin
      if (host.wr_data && !host.set_ptr && !host.wr_fade_cmd) begin
         if (fade_r) begin
            fade_mem[ptr_r[6:0]] <= host.data;
         end else if (gray_mode) begin
            gray_mem[ptr_r] <= host.data;
         end else begin
            bin_mem[ptr_r[4:0]] <= host.data;
         end
      end
   end

   // ----------------------------------------
   // Dot lookup for the scanner
   // ----------------------------------------
   // Decode common and dot to address and bit; out-of-layout dots read dark
   always_comb begin
      logic [7:0] addr;
      logic [7:0] byte_v;
      logic [2:0] bitn;
      logic valid;
      logic [3:0] pair;
      addr = 8'h00;
      byte_v = 8'h00;
      bitn = 3'h0;
      valid = 1'b0;
      pair = 4'h0;
      case (matrix_type)
         ldr_pkg::LDR_TYPE_9X10: begin
            valid = (scan.common < 4'd10) && (scan.dot < 5'd18);
            if (gray_mode) begin
               addr = 8'(scan.common * 8'd18 + 8'(scan.dot));
            end else begin
               addr = 8'(scan.common * 8'd3 + 8'(scan.dot[4:3]));
               bitn = scan.dot[2:0];
            end
         end
         ldr_pkg::LDR_TYPE_12X12: begin
            valid = (scan.common < 4'd12) && (scan.dot < 5'd12);
            pair = {1'b0, scan.common[3:1]};
            if (gray_mode) begin
               addr = {scan.common, scan.dot[3:0]};
            end else if (!scan.common[0]) begin
               addr = 8'(pair * 8'd3 + (scan.dot >= 5'd8 ? 8'd1 : 8'd0));
               bitn = scan.dot[2:0];
            end else begin
               addr = 8'(pair * 8'd3 + (scan.dot >= 5'd4 ? 8'd2 : 8'd1));
               bitn = scan.dot >= 5'd4 ? 3'(scan.dot - 5'd4) : 3'(scan.dot + 5'd4);
            end
         end
         default: begin
            valid = (scan.dot < 5'd16);
            if (gray_mode) begin
               addr = {scan.common, scan.dot[3:0]};
            end else begin
               addr = {3'h0, scan.common, scan.dot[3]};
               bitn = scan.dot[2:0];
            end
         end
      endcase
      if (gray_mode) begin
         byte_v = gray_mem[addr];
         level_nxt = valid ? byte_v : 8'h00;
      end else begin
         byte_v = bin_mem[addr[4:0]];
         level_nxt = (valid && byte_v[bitn]) ? 8'hFF : 8'h00;
      end
      fade_out_nxt = (valid && gray_mode) ? fade_mem[addr[6:0]] : 8'h00;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         level_r <= 8'h00;
         fade_out_r <= 8'h00;
      end else begin
         level_r <= level_nxt;
         fade_out_r <= fade_out_nxt;
      end
   end

   assign ptr = ptr_r;
   assign fade_sel = fade_r;
   assign dot_level = level_r;
   assign dot_fade = fade_out_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_set_ptr;
      @(posedge clk) disable iff (srst) host.set_ptr |=> (ptr == $past(host.data));
   endproperty
   a_set_ptr: assert property (p_set_ptr) else $error("pointer not loaded");

   property p_inc;
      @(posedge clk) disable iff (srst)
         (host.wr_data && !host.set_ptr && !host.wr_fade_cmd
          && ptr < last_addr(matrix_type, gray_mode, fade_sel)) |=> ptr == $past(ptr) + 8'h01;
   endproperty
   a_inc: assert property (p_inc) else $error("pointer did not step");

   property p_wrap;
      @(posedge clk) disable iff (srst)
         (host.wr_data && !host.set_ptr && !host.wr_fade_cmd
          && ptr >= last_addr(matrix_type, gray_mode, fade_sel)) |=> ptr == 8'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

   property p_wrap16;
      @(posedge clk) disable iff (srst)
         (host.wr_data && !host.set_ptr && !host.wr_fade_cmd && !fade_sel && gray_mode
          && matrix_type == ldr_pkg::LDR_TYPE_16X16 && ptr == 8'hFF) |=> ptr == 8'h00;
   endproperty
   a_wrap16: assert property (p_wrap16) else $error("gray 16x16 wrap wrong");

   property p_fade_cmd;
      @(posedge clk) disable iff (srst)
         (host.wr_fade_cmd && !host.set_ptr) |=> fade_sel;
   endproperty
   a_fade_cmd: assert property (p_fade_cmd) else $error("fade select missing");

   property p_invalid_dark;
      @(posedge clk) disable iff (srst)
         (matrix_type == ldr_pkg::LDR_TYPE_12X12 && scan.dot >= 5'd12) |=> dot_level == 8'h00;
   endproperty
   a_invalid_dark: assert property (p_invalid_dark) else $error("phantom dot lit");

   property p_bin_level;
      @(posedge clk) disable iff (srst) !gray_mode |=> (dot_level == 8'h00 || dot_level == 8'hFF);
   endproperty
   a_bin_level: assert property (p_bin_level) else $error("binary level not on/off");

   property p_bin_fade;
      @(posedge clk) disable iff (srst) !gray_mode |=> dot_fade == 8'h00;
   endproperty
   a_bin_fade: assert property (p_bin_fade) else $error("fade used in binary");

   c_burst: cover property (@(posedge clk) host.set_ptr ##1 host.wr_data [*3]);
   c_wrap: cover property (@(posedge clk) host.wr_data && ptr == 8'h1D ##1 ptr == 8'h00);
   c_fade: cover property (@(posedge clk) host.wr_fade_cmd ##1 host.wr_data);
endmodule

// *** tb/ldr_host_model.sv ***
// Host-side model that issues pointer, fade and data requests
`timescale 1ns/100ps
module ldr_host_model (
   // Clock
   input wire logic clk,
   // Host stream
   output ldr_pkg::ldr_host_s host
);
   initial host = '0;
   // One-cycle pulse; data turns to its inverse once released
   // k: 4 = set pointer 2 = fade command 1 = data write
   task automatic req(input logic [2:0] k, input logic [7:0] d);
      @(negedge clk);
      host <= {k, d};
      @(negedge clk);
      host <= {3'h0, ~d};
   endtask
endmodule

// *** tb/test_ldr_ram_map.sv ***
// Self-checking bench for the display memory address map
`timescale 1ns/100ps
module test_ldr_ram_map;
   // ---------------------------------
   // Stimulus and observed signals
   // ---------------------------------
   logic clk = 1'b0;
   logic srst = 1'b1;
   ldr_pkg::ldr_matrix_e matrix_type = ldr_pkg::LDR_TYPE_9X10;
   logic gray_mode = 1'b0;
   ldr_pkg::ldr_host_s host;
   // Parked on a dot that no layout has, so reads of unwritten memory are masked to zero
   localparam ldr_pkg::ldr_dot_s SCAN_IDLE = '{common: 4'h0, dot: 5'h1F};
   ldr_pkg::ldr_dot_s scan = SCAN_IDLE;
   logic [7:0] ptr;
   logic fade_sel;
   logic [7:0] dot_level;
   logic [7:0] dot_fade;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   always #50 clk = ~clk;
   ldr_host_model u_host (.clk(clk), .host(host));
   ldr_ram_map u_dut (.clk(clk), .srst(srst), .matrix_type(matrix_type),
      .gray_mode(gray_mode), .host(host), .scan(scan), .ptr(ptr),
      .fade_sel(fade_sel), .dot_level(dot_level), .dot_fade(dot_fade));
   // ---------------------------------
   // Shared tasks
   // ---------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons=%0d mismatches=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Pick layout, then load the pointer
   task automatic setup(input ldr_pkg::ldr_matrix_e m, input logic g, input logic [7:0] a);
      @(negedge clk);
      matrix_type = m;
      gray_mode = g;
      u_host.req(3'h4, a);
   endtask
   // Scan one dot, read back one cycle later, then park the scan again
   task automatic look(input logic [3:0] c, input logic [4:0] d, input logic [7:0] e);
      @(negedge clk);
      scan = '{common: c, dot: d};
      @(negedge clk);
      chk8(dot_level, e);
      scan = SCAN_IDLE;
   endtask
   // ---------------------------------
   // Scenarios
   // ---------------------------------
   task automatic t_bin9();
      setup(ldr_pkg::LDR_TYPE_9X10, 1'b0, 8'h1C);
      u_host.req(3'h1, 8'hAA);
      chk8(ptr, 8'h1D);
      u_host.req(3'h1, 8'h55);
      chk8(ptr, 8'h00);
      look(4'h9, 5'h09, 8'hFF);
      look(4'h9, 5'h08, 8'h00);
      look(4'h9, 5'h10, 8'hFF);
      look(4'h9, 5'h12, 8'h00);
      $display("bin 9x10 done");
   endtask
   task automatic t_bin12();
      setup(ldr_pkg::LDR_TYPE_12X12, 1'b0, 8'h10);
      u_host.req(3'h1, 8'h3C);
      u_host.req(3'h1, 8'h81);
      chk8(ptr, 8'h00);
      look(4'hA, 5'h0A, 8'hFF);
      look(4'hA, 5'h08, 8'h00);
      look(4'hB, 5'h00, 8'hFF);
      look(4'hB, 5'h04, 8'hFF);
      look(4'hB, 5'h05, 8'h00);
      $display("bin 12x12 done");
   endtask
   task automatic t_bin16();
      setup(ldr_pkg::LDR_TYPE_16X16, 1'b0, 8'h1F);
      u_host.req(3'h1, 8'h80);
      chk8(ptr, 8'h00);
      look(4'hF, 5'h0F, 8'hFF);
      look(4'hF, 5'h0E, 8'h00);
      $display("bin 16x16 done");
   endtask
   // Write the last byte, wrap, write address zero; probe one dot past the row
   task automatic t_gray(input ldr_pkg::ldr_matrix_e m, input logic [7:0] a,
      input logic [3:0] c, input logic [4:0] d, input logic [7:0] v);
      setup(m, 1'b1, a);
      u_host.req(3'h1, v);
      chk8(ptr, 8'h00);
      u_host.req(3'h1, ~v);
      chk8(ptr, 8'h01);
      look(c, d, v);
      look(4'h0, 5'h00, ~v);
      look(c, d + 5'h01, 8'h00);
      $display("gray done");
   endtask
   task automatic t_fade();
      setup(ldr_pkg::LDR_TYPE_16X16, 1'b1, 8'h7F);
      u_host.req(3'h1, 8'h11);
      u_host.req(3'h4, 8'h7F);
      u_host.req(3'h2, ldr_pkg::LDR_CMD_WR_FADE);
      chk8({7'h00, fade_sel}, 8'h01);
      u_host.req(3'h1, 8'h9E);
      chk8(ptr, 8'h00);
      look(4'h7, 5'h0F, 8'h11);
      chk8(dot_fade, 8'h9E);
      u_host.req(3'h4, 8'h00);
      chk8({7'h00, fade_sel}, 8'h00);
      $display("fade done");
   endtask
   // Mid-run reset clears pointer and select but keeps memory contents
   task automatic t_reset();
      setup(ldr_pkg::LDR_TYPE_16X16, 1'b1, 8'h40);
      u_host.req(3'h2, ldr_pkg::LDR_CMD_WR_FADE);
      chk8(ptr, 8'h40);
      chk8({7'h00, fade_sel}, 8'h01);
      @(negedge clk);
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      chk8(ptr, 8'h00);
      chk8({7'h00, fade_sel}, 8'h00);
      look(4'h0, 5'h00, 8'h38);
      $display("reset done");
   endtask
   // ---------------------------------
   // Hang guard and main sequence
   // ---------------------------------
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         report_and_stop();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      chk8(ptr, 8'h00);
      chk8(dot_level, 8'h00);
      chk8(dot_fade, 8'h00);
      t_bin9();
      t_bin12();
      t_bin16();
      t_gray(ldr_pkg::LDR_TYPE_9X10, 8'hB3, 4'h9, 5'h11, 8'h5A);
      t_gray(ldr_pkg::LDR_TYPE_12X12, 8'hBB, 4'hB, 5'h0B, 8'h33);
      t_gray(ldr_pkg::LDR_TYPE_16X16, 8'hFF, 4'hF, 5'h0F, 8'hC7);
      t_fade();
      t_reset();
      report_and_stop();
   end
endmodule
